// ==== design/pin_mux_pkg.sv ====
// constants shared by the port f/g/h pin function selection block
package pin_mux_pkg;
  // ****************************************************
  // register map (apb byte addresses)
  // ****************************************************
  localparam logic [7:0] OFF_F_EXTRA = 8'h00;
  localparam logic [7:0] OFF_G_DIR = 8'h04;
  localparam logic [7:0] OFF_G_UPPER = 8'h08;
  localparam logic [7:0] OFF_G_LOWER = 8'h0C;
  localparam logic [7:0] OFF_H_DIR = 8'h10;
  localparam logic [7:0] OFF_PAD_G_LEVEL = 8'h14;
  localparam logic [7:0] OFF_PAD_FH_LEVEL = 8'h18;

  // ****************************************************
  // reset values and writable masks
  // ****************************************************
  localparam logic [15:0] REG_RESET = 16'h0000;
  localparam logic [15:0] F_EXTRA_MASK = 16'hF000;
  localparam logic [15:0] H_DIR_MASK = 16'h003F;
  localparam logic [15:0] G_DIR_MASK = 16'hFFFF;
  localparam logic [15:0] G_FUNC_MASK = 16'hFFFF;

  // ****************************************************
  // field positions
  // ****************************************************
  localparam int F15_EXTRA_LSB = 14;
  localparam int F14_EXTRA_LSB = 12;
  localparam int H_PIN_COUNT = 6;
  localparam int G_PIN_COUNT = 16;

  // ****************************************************
  // selection codes
  // ****************************************************
  localparam logic [1:0] CODE_GPIO = 2'h0;
  localparam logic [1:0] CODE_ALT1 = 2'h1;
  localparam logic [1:0] CODE_ALT2 = 2'h2;
  localparam logic [1:0] CODE_ALT3 = 2'h3;

  // kind of connection a code makes on a pin
  localparam logic [1:0] KIND_NONE = 2'h0;
  localparam logic [1:0] KIND_OUT = 2'h1;
  localparam logic [1:0] KIND_IN = 2'h2;
  localparam logic [1:0] KIND_BIDIR = 2'h3;

  // per port g pin kind of code 10, two bits per pin, pin 15 first
  localparam logic [31:0] G_KIND_CODE2 = {
    KIND_OUT, KIND_OUT, KIND_OUT, KIND_OUT,
    KIND_OUT, KIND_OUT, KIND_BIDIR, KIND_OUT,
    KIND_OUT, KIND_BIDIR, KIND_OUT, KIND_OUT,
    KIND_OUT, KIND_OUT, KIND_OUT, KIND_BIDIR};
  // per port g pin kind of code 11, pin 15 first
  localparam logic [31:0] G_KIND_CODE3 = {
    KIND_IN, KIND_IN, KIND_IN, KIND_IN,
    KIND_IN, KIND_IN, KIND_IN, KIND_IN,
    KIND_NONE, KIND_NONE, KIND_OUT, KIND_OUT,
    KIND_NONE, KIND_NONE, KIND_NONE, KIND_NONE};

  // ****************************************************
  // apb answer timing
  // ****************************************************
  localparam int APB_WAIT_CYCLES = 1;
endpackage : pin_mux_pkg

// ==== design/pin_route_cell.sv ====
// per pin selection of general i/o or one peripheral signal
`timescale 1ns/1ps
module pin_route_cell #(
  parameter logic [1:0] KIND2 = pin_mux_pkg::KIND_OUT,
  parameter logic [1:0] KIND3 = pin_mux_pkg::KIND_IN
) (
  input wire logic [1:0] code_i,
  input wire logic dir_i,
  input wire logic gpio_i,
  input wire logic alt1_i,
  input wire logic alt2_i,
  input wire logic alt2_oe_i,
  input wire logic alt3_i,
  output logic pad_out_o,
  output logic pad_oe_o,
  output logic gpio_mode_o,
  output logic in2_o,
  output logic in3_o
);
  // ****************************************************
  // pin routing
  // ****************************************************
  // drive pad from gpio or from the selected peripheral
  always_comb begin
    pad_out_o = gpio_i;
    pad_oe_o = dir_i;
    gpio_mode_o = 1'b1;
    in2_o = 1'b0;
    in3_o = 1'b0;
    case (code_i)
      pin_mux_pkg::CODE_ALT1: begin
        pad_out_o = alt1_i;
        pad_oe_o = 1'b1;
        gpio_mode_o = 1'b0;
      end
      pin_mux_pkg::CODE_ALT2: begin
        if (KIND2 != pin_mux_pkg::KIND_NONE) begin
          pad_out_o = alt2_i;
          pad_oe_o = (KIND2 == pin_mux_pkg::KIND_OUT) |
            ((KIND2 == pin_mux_pkg::KIND_BIDIR) & alt2_oe_i);
          gpio_mode_o = 1'b0;
          in2_o = (KIND2 != pin_mux_pkg::KIND_OUT);
        end
      end
      pin_mux_pkg::CODE_ALT3: begin
        if (KIND3 != pin_mux_pkg::KIND_NONE) begin
          pad_out_o = (KIND3 == pin_mux_pkg::KIND_IN) ? 1'b0 : alt3_i;
          pad_oe_o = (KIND3 == pin_mux_pkg::KIND_OUT);
          gpio_mode_o = 1'b0;
          in3_o = (KIND3 == pin_mux_pkg::KIND_IN);
        end
      end
      // prohibited kinds fall through as general i/o
      default: begin
        pad_out_o = gpio_i;
      end
    endcase
  end
endmodule : pin_route_cell

// ==== design/port_fgh_pin_function_select.sv ====
// pin function selection for port f extra, port g and port h direction
// Summary of operation
// - f15 extra field 15:14: 00 general i/o, 11 bus b receive.
// - f15 extra field acts only while f15 primary field is 00.
// - f14 extra field 13:12: 00 general i/o, 11 bus b transmit.
// - f14 extra field acts only while f14 primary field is 00.
// - reserved bits read zero; software writes zero to them.
// - all registers clear to zero on reset, kept through sleep.
// - direction bit 0 makes pin input, 1 makes it output.
// - direction bit only matters while the pin is general i/o.
// - port g direction bits 15..0 map to pins 15..0.
// - port h direction bits 5..0 map to pins 5..0.
// - upper g fields: 00 general i/o, 01 timer output channel.
// - code 10 on upper g pins routes spi slave selects out.
// - code 10 on g9 routes bidirectional spi c select 0.
// - code 11 on g15..g8 feeds timer inputs 13..6.
// - lower g fields: 00 general i/o, 01 timer output channel.
// - g7,g3..g1 code 10 spi selects; code 11 prohibited there.
// - g6 and g0 code 10 route bidirectional spi selects 0.
// - g5: 10 spi a 5, 11 spi c 3; g4: spi a 4, spi b 3.
// - f15 primary field: 00 gpio, 01 timer, 10 can, 11 serial.
//
// Decided for this implementation: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
module port_fgh_pin_function_select (
  input wire logic core_clk_i,
  input wire logic srst_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // port f primary fields and port h function state
  input wire logic [1:0] pin_f15_primary_field_i,
  input wire logic [1:0] pin_f14_primary_field_i,
  input wire logic [5:0] port_h_gpio_mode_i,
  // port data registers
  input wire logic [15:0] gpio_g_data_i,
  input wire logic [5:0] gpio_h_data_i,
  // peripheral side
  input wire logic [15:0] timer_output_a_i,
  input wire logic [7:0] spi_a_select_i,
  input wire logic [3:0] spi_b_select_i,
  input wire logic [3:0] spi_c_select_i,
  input wire logic spi_a_select_0_oe_i,
  input wire logic spi_b_select_0_oe_i,
  input wire logic spi_c_select_0_oe_i,
  input wire logic ttbus_b_transmit_i,
  output logic ttbus_b_receive_o,
  output logic [13:6] timer_input_o,
  output logic spi_a_select_0_in_o,
  output logic spi_b_select_0_in_o,
  output logic spi_c_select_0_in_o,
  // pads
  input wire logic [15:0] pad_g_in_i,
  output logic [15:0] pad_g_out_o,
  output logic [15:0] pad_g_oe_o,
  input wire logic [5:0] pad_h_in_i,
  output logic [5:0] pad_h_out_o,
  output logic [5:0] pad_h_oe_o,
  input wire logic pad_f15_in_i,
  output logic pad_f14_out_o,
  output logic pad_f14_oe_o,
  output logic [1:0] f_extra_own_o
);
  // ****************************************************
  // storage
  // ****************************************************
  logic [15:0] f_extra_q;
  logic [15:0] g_dir_q;
  logic [15:0] g_upper_q;
  logic [15:0] g_lower_q;
  logic [15:0] h_dir_q;
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic [15:0] g_meta_q;
  logic [15:0] g_sync_q;
  logic [5:0] h_meta_q;
  logic [5:0] h_sync_q;
  logic f15_meta_q;
  logic f15_sync_q;
  logic [15:0] g_out_q;
  logic [15:0] g_oe_q;
  logic [5:0] h_out_q;
  logic [5:0] h_oe_q;
  logic f14_out_q;
  logic f14_oe_q;
  logic [1:0] own_q;
  logic rx_q;
  logic [13:6] tin_q;
  logic [2:0] sel0_in_q;

  // ****************************************************
  // decode helpers
  // ****************************************************
  // true when address selects the given word
  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    hit = (a[7:2] == o[7:2]);
  endfunction : hit

  // true when address is a mapped register
  function automatic logic mapped(input logic [7:0] a);
    mapped = hit(a, pin_mux_pkg::OFF_F_EXTRA) |
      hit(a, pin_mux_pkg::OFF_G_DIR) |
      hit(a, pin_mux_pkg::OFF_G_UPPER) |
      hit(a, pin_mux_pkg::OFF_G_LOWER) |
      hit(a, pin_mux_pkg::OFF_H_DIR) |
      hit(a, pin_mux_pkg::OFF_PAD_G_LEVEL) |
      hit(a, pin_mux_pkg::OFF_PAD_FH_LEVEL);
  endfunction : mapped

  // ****************************************************
  // apb handshake
  // ****************************************************
  logic access;
  logic wr_en;
  logic [15:0] wdata;
  assign access = psel_i & penable_i & pready_q;
  assign wr_en = access & pwrite_i & mapped(paddr_i);
  assign wdata = pwdata_i[15:0];

  // one wait state, then pready for a single cycle
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= psel_i & penable_i & ~pready_q;
      pslverr_q <= psel_i & penable_i & ~pready_q & ~mapped(paddr_i);
    end
  end

  // read data mux, reserved and upper bits read zero
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h00000000;
    if (hit(paddr_i, pin_mux_pkg::OFF_F_EXTRA)) begin
      rd_mux[15:0] = f_extra_q & pin_mux_pkg::F_EXTRA_MASK;
    end else if (hit(paddr_i, pin_mux_pkg::OFF_G_DIR)) begin
      rd_mux[15:0] = g_dir_q;
    end else if (hit(paddr_i, pin_mux_pkg::OFF_G_UPPER)) begin
      rd_mux[15:0] = g_upper_q;
    end else if (hit(paddr_i, pin_mux_pkg::OFF_G_LOWER)) begin
      rd_mux[15:0] = g_lower_q;
    end else if (hit(paddr_i, pin_mux_pkg::OFF_H_DIR)) begin
      rd_mux[15:0] = h_dir_q & pin_mux_pkg::H_DIR_MASK;
    end else if (hit(paddr_i, pin_mux_pkg::OFF_PAD_G_LEVEL)) begin
      rd_mux[15:0] = g_sync_q;
    end else if (hit(paddr_i, pin_mux_pkg::OFF_PAD_FH_LEVEL)) begin
      rd_mux[6:0] = {f15_sync_q, h_sync_q};
    end
  end

  // capture read data together with pready
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      prdata_q <= 32'h00000000;
    end else if (psel_i & penable_i & ~pready_q & ~pwrite_i) begin
      prdata_q <= rd_mux;
    end else begin
      prdata_q <= 32'h00000000;
    end
  end

  // ****************************************************
  // control registers
  // ****************************************************
  // cleared by reset, otherwise changed only by apb writes
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      f_extra_q <= pin_mux_pkg::REG_RESET;
      g_dir_q <= pin_mux_pkg::REG_RESET;
      g_upper_q <= pin_mux_pkg::REG_RESET;
      g_lower_q <= pin_mux_pkg::REG_RESET;
      h_dir_q <= pin_mux_pkg::REG_RESET;
    end else if (wr_en) begin
      if (hit(paddr_i, pin_mux_pkg::OFF_F_EXTRA)) begin
        f_extra_q <= wdata & pin_mux_pkg::F_EXTRA_MASK;
      end
      if (hit(paddr_i, pin_mux_pkg::OFF_G_DIR)) begin
        g_dir_q <= wdata & pin_mux_pkg::G_DIR_MASK;
      end
      if (hit(paddr_i, pin_mux_pkg::OFF_G_UPPER)) begin
        g_upper_q <= wdata & pin_mux_pkg::G_FUNC_MASK;
      end
      if (hit(paddr_i, pin_mux_pkg::OFF_G_LOWER)) begin
        g_lower_q <= wdata & pin_mux_pkg::G_FUNC_MASK;
      end
      if (hit(paddr_i, pin_mux_pkg::OFF_H_DIR)) begin
        h_dir_q <= wdata & pin_mux_pkg::H_DIR_MASK;
      end
    end
  end

  // ****************************************************
  // pad input synchronisers
  // ****************************************************
  // two flops before any logic looks at a pad
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      g_meta_q <= 16'h0000;
      g_sync_q <= 16'h0000;
      h_meta_q <= 6'h00;
      h_sync_q <= 6'h00;
      f15_meta_q <= 1'b1;
      f15_sync_q <= 1'b1;
    end else begin
      g_meta_q <= pad_g_in_i;
      g_sync_q <= g_meta_q;
      h_meta_q <= pad_h_in_i;
      h_sync_q <= h_meta_q;
      f15_meta_q <= pad_f15_in_i;
      f15_sync_q <= f15_meta_q;
    end
  end

  // ****************************************************
  // port g routing
  // ****************************************************
  logic [31:0] g_codes;
  logic [15:0] alt2_vec;
  logic [15:0] alt2_oe_vec;
  logic [15:0] alt3_vec;
  logic [15:0] g_out_d;
  logic [15:0] g_oe_d;
  logic [15:0] in2_vec;
  logic [15:0] in3_vec;

  assign g_codes = {g_upper_q, g_lower_q};

  // spi select outputs per pin for code 10
  assign alt2_vec = {spi_a_select_i[7:4], spi_c_select_i[2:0],
    spi_b_select_i[2], spi_b_select_i[1:0], spi_a_select_i[5:4],
    spi_a_select_i[3:0]};
  // only g9, g6 and g0 may turn their pad around
  assign alt2_oe_vec = {6'h00, spi_c_select_0_oe_i, 2'h0,
    spi_b_select_0_oe_i, 5'h00, spi_a_select_0_oe_i};
  // code 11 outputs exist only on g5 and g4
  assign alt3_vec = {10'h000, spi_c_select_i[3], spi_b_select_i[3],
    4'h0};

  // one cell per pin, field 2n+1:2n drives pin n
  genvar gi;
  generate
    for (gi = 0; gi < pin_mux_pkg::G_PIN_COUNT; gi++) begin : g_pin
      pin_route_cell #(
        .KIND2(pin_mux_pkg::G_KIND_CODE2[2*gi +: 2]),
        .KIND3(pin_mux_pkg::G_KIND_CODE3[2*gi +: 2])
      ) u_cell (
        .code_i(g_codes[2*gi +: 2]),
        .dir_i(g_dir_q[gi]),
        .gpio_i(gpio_g_data_i[gi]),
        .alt1_i(timer_output_a_i[gi]),
        .alt2_i(alt2_vec[gi]),
        .alt2_oe_i(alt2_oe_vec[gi]),
        .alt3_i(alt3_vec[gi]),
        .pad_out_o(g_out_d[gi]),
        .pad_oe_o(g_oe_d[gi]),
        .gpio_mode_o(),
        .in2_o(in2_vec[gi]),
        .in3_o(in3_vec[gi])
      );
    end
  endgenerate

  // ****************************************************
  // port f extra selection
  // ****************************************************
  logic own15_d;
  logic own14_d;
  // extra code 11 wins only over a primary general i/o field
  assign own15_d = (pin_f15_primary_field_i == pin_mux_pkg::CODE_GPIO)
    & (f_extra_q[pin_mux_pkg::F15_EXTRA_LSB +: 2] ==
    pin_mux_pkg::CODE_ALT3);
  assign own14_d = (pin_f14_primary_field_i == pin_mux_pkg::CODE_GPIO)
    & (f_extra_q[pin_mux_pkg::F14_EXTRA_LSB +: 2] ==
    pin_mux_pkg::CODE_ALT3);

  // ****************************************************
  // registered pad and peripheral outputs
  // ****************************************************
  // pad drive, direction only counts in general i/o mode
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      g_out_q <= 16'h0000;
      g_oe_q <= 16'h0000;
      h_out_q <= 6'h00;
      h_oe_q <= 6'h00;
      f14_out_q <= 1'b0;
      f14_oe_q <= 1'b0;
      own_q <= 2'h0;
    end else begin
      g_out_q <= g_out_d;
      g_oe_q <= g_oe_d;
      h_out_q <= gpio_h_data_i;
      h_oe_q <= h_dir_q[5:0] & port_h_gpio_mode_i;
      f14_out_q <= own14_d & ttbus_b_transmit_i;
      f14_oe_q <= own14_d;
      own_q <= {own15_d, own14_d};
    end
  end

  // receive and select inputs idle high, timer inputs idle low, unless their one pin is selected
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      rx_q <= 1'b1;
      tin_q <= 8'h00;
      sel0_in_q <= 3'h7;
    end else begin
      rx_q <= own15_d ? f15_sync_q : 1'b1;
      tin_q <= g_sync_q[15:8] & in3_vec[15:8];
      sel0_in_q[0] <= in2_vec[0] ? g_sync_q[0] : 1'b1;
      sel0_in_q[1] <= in2_vec[6] ? g_sync_q[6] : 1'b1;
      sel0_in_q[2] <= in2_vec[9] ? g_sync_q[9] : 1'b1;
    end
  end

  // ****************************************************
  // output assignments
  // ****************************************************
  assign prdata_o = prdata_q;
  assign pready_o = pready_q;
  assign pslverr_o = pslverr_q;
  assign pad_g_out_o = g_out_q;
  assign pad_g_oe_o = g_oe_q;
  assign pad_h_out_o = h_out_q;
  assign pad_h_oe_o = h_oe_q;
  assign pad_f14_out_o = f14_out_q;
  assign pad_f14_oe_o = f14_oe_q;
  assign f_extra_own_o = own_q;
  assign ttbus_b_receive_o = rx_q;
  assign timer_input_o = tin_q;
  assign spi_a_select_0_in_o = sel0_in_q[0];
  assign spi_b_select_0_in_o = sel0_in_q[1];
  assign spi_c_select_0_in_o = sel0_in_q[2];
endmodule : port_fgh_pin_function_select

// ==== sim/port_fgh_asserts.sv ====
// assertion checker for the port f/g/h pin function block
`timescale 1ns/1ps
module port_fgh_checker (
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic [1:0] pin_f15_primary_field_i,
  input wire logic [1:0] pin_f14_primary_field_i,
  input wire logic [5:0] port_h_gpio_mode_i,
  input wire logic ttbus_b_transmit_i,
  input wire logic ttbus_b_receive_o,
  input wire logic [15:0] pad_g_oe_o,
  input wire logic [5:0] pad_h_oe_o,
  input wire logic pad_f14_out_o,
  input wire logic pad_f14_oe_o,
  input wire logic [1:0] f_extra_own_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (srst_i);
  // ****************************************************
  // bus phases
  // ****************************************************
  sequence apb_setup;
    psel_i && !penable_i;
  endsequence
  sequence apb_access;
    psel_i && penable_i && !pready_o;
  endsequence
  sequence apb_read_done;
    pready_o && !pwrite_i;
  endsequence
  // ****************************************************
  // properties
  // ****************************************************
  AST_WAIT_STATE: assert property (apb_setup ##1 apb_access |=> pready_o)
    else $error("pready missing after one wait state");
  AST_READY_PULSE: assert property (pready_o |=> !pready_o)
    else $error("pready stands longer than one cycle");
  AST_RESET_CLEAR: assert property ($fell(srst_i) |->
    !pready_o && prdata_o == 32'h0 && pad_g_oe_o == 16'h0000 &&
    pad_h_oe_o == 6'h00 && f_extra_own_o == 2'h0 && ttbus_b_receive_o)
    else $error("outputs not cleared by reset");
  AST_F_RESERVED: assert property (
    apb_read_done ##0 paddr_i[7:2] == 6'h00 |->
    prdata_o[11:0] == 12'h000 && prdata_o[31:16] == 16'h0000)
    else $error("reserved port f bits read nonzero");
  AST_H_RESERVED: assert property (
    apb_read_done ##0 paddr_i[7:2] == 6'h04 |->
    prdata_o[31:6] == 26'h0)
    else $error("reserved port h bits read nonzero");
  AST_H_OE_GPIO: assert property (1'b1 |=>
    (pad_h_oe_o & ~$past(port_h_gpio_mode_i)) == 6'h00)
    else $error("port h pin driven outside general i/o");
  AST_F14_GATE: assert property (f_extra_own_o[0] |->
    $past(pin_f14_primary_field_i) == 2'h0)
    else $error("f14 taken while primary field not zero");
  AST_F15_GATE: assert property (f_extra_own_o[1] |->
    $past(pin_f15_primary_field_i) == 2'h0)
    else $error("f15 taken while primary field not zero");
  AST_F14_OE: assert property (pad_f14_oe_o |->
    $past(pin_f14_primary_field_i) == 2'h0 && f_extra_own_o[0])
    else $error("f14 driven while primary field not zero");
  AST_F14_DATA: assert property (
    f_extra_own_o[0] && $past(f_extra_own_o[0]) |->
    pad_f14_out_o == $past(ttbus_b_transmit_i))
    else $error("f14 does not carry transmit data");
  AST_F15_IDLE: assert property (!f_extra_own_o[1] &&
    !$past(f_extra_own_o[1]) |-> ttbus_b_receive_o)
    else $error("receive input not idle high");
endmodule : port_fgh_checker

bind port_fgh_pin_function_select port_fgh_checker u_chk (.core_clk_i,
  .srst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .prdata_o, .pready_o,
  .pin_f15_primary_field_i, .pin_f14_primary_field_i, .port_h_gpio_mode_i,
  .ttbus_b_transmit_i, .ttbus_b_receive_o, .pad_g_oe_o, .pad_h_oe_o,
  .pad_f14_out_o, .pad_f14_oe_o, .f_extra_own_o);

// ==== sim/pad_far_side.sv ====
// pad model: driven pins show the block's value, others the board's
`timescale 1ns/1ps
module pad_far_side (
  input wire logic [15:0] g_out_i,
  input wire logic [15:0] g_oe_i,
  input wire logic [15:0] g_board_i,
  output logic [15:0] g_level_o,
  input wire logic [5:0] h_out_i,
  input wire logic [5:0] h_oe_i,
  input wire logic [5:0] h_board_i,
  output logic [5:0] h_level_o
);
  // oe high means the block drives the pin
  assign g_level_o = (g_oe_i & g_out_i) | (~g_oe_i & g_board_i);
  assign h_level_o = (h_oe_i & h_out_i) | (~h_oe_i & h_board_i);
endmodule : pad_far_side

// ==== sim/port_fgh_pin_function_select_tb.sv ====
// self-checking bench for the port f/g/h pin function block
`timescale 1ns/1ps
module port_fgh_pin_function_select_tb;
  logic core_clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0;
  logic [1:0] f15p = 2'h0;
  logic [1:0] f14p = 2'h0;
  logic [5:0] hmode = 6'h3F;
  logic [15:0] gdat = 16'h3C5A;
  logic [5:0] hdat = 6'h15;
  logic [15:0] tmr = 16'hC3A5;
  logic [7:0] spa = 8'h96;
  logic [3:0] spb = 4'hB;
  logic [3:0] spc = 4'h5;
  logic [2:0] s0oe = 3'h5;
  logic [15:0] sel_map;
  logic tx = 1'b1;
  logic f15_in = 1'b0;
  logic [15:0] g_board = 16'h6D2B;
  logic [5:0] h_board = 6'h0C;
  logic [31:0] prdata_o;
  logic pready_o, pslverr_o, rx, a_in, b_in, c_in, f14_out, f14_oe;
  logic [13:6] tin;
  logic [15:0] g_out, g_oe, g_lvl;
  logic [5:0] h_out, h_oe, h_lvl;
  logic [1:0] own;
  int err_total = 0;
  int total_checks = 0;
  localparam logic [7:0] F = pin_mux_pkg::OFF_F_EXTRA;
  localparam logic [7:0] GD = pin_mux_pkg::OFF_G_DIR;
  localparam logic [7:0] GU = pin_mux_pkg::OFF_G_UPPER;
  localparam logic [7:0] GL = pin_mux_pkg::OFF_G_LOWER;
  localparam logic [7:0] HD = pin_mux_pkg::OFF_H_DIR;

  // 25 MHz clock
  always #20 core_clk_i = ~core_clk_i;

  port_fgh_pin_function_select DUT (.core_clk_i, .srst_i, .psel_i,
    .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o,
    .pslverr_o, .pin_f15_primary_field_i(f15p),
    .pin_f14_primary_field_i(f14p), .port_h_gpio_mode_i(hmode),
    .gpio_g_data_i(gdat), .gpio_h_data_i(hdat), .timer_output_a_i(tmr),
    .spi_a_select_i(spa), .spi_b_select_i(spb), .spi_c_select_i(spc),
    .spi_a_select_0_oe_i(s0oe[0]), .spi_b_select_0_oe_i(s0oe[1]),
    .spi_c_select_0_oe_i(s0oe[2]), .ttbus_b_transmit_i(tx),
    .ttbus_b_receive_o(rx), .timer_input_o(tin),
    .spi_a_select_0_in_o(a_in), .spi_b_select_0_in_o(b_in),
    .spi_c_select_0_in_o(c_in), .pad_g_in_i(g_lvl), .pad_g_out_o(g_out),
    .pad_g_oe_o(g_oe), .pad_h_in_i(h_lvl), .pad_h_out_o(h_out),
    .pad_h_oe_o(h_oe), .pad_f15_in_i(f15_in), .pad_f14_out_o(f14_out),
    .pad_f14_oe_o(f14_oe), .f_extra_own_o(own));

  pad_far_side u_pads (.g_out_i(g_out), .g_oe_i(g_oe), .g_board_i(g_board),
    .g_level_o(g_lvl), .h_out_i(h_out), .h_oe_i(h_oe),
    .h_board_i(h_board), .h_level_o(h_lvl));

  // ****************************************************
  // access and compare tasks
  // ****************************************************
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp

  task automatic apb(input logic wr, input logic [7:0] a,
    input logic [15:0] d, output logic [31:0] q, output logic e);
    @(posedge core_clk_i);
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= {16'h0000, d};
    @(posedge core_clk_i);
    penable_i <= 1'b1;
    @(posedge core_clk_i);
    // wait for the answer, only the watchdog ends a hang
    while (pready_o !== 1'b1) begin
      @(posedge core_clk_i);
    end
    q = prdata_o;
    e = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] x,
    input logic xe);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 16'h0000, q, e);
    cmp(q, x);
    cmp(32'(e), 32'(xe));
  endtask : rd

  // pins checked after syncs and output registers have settled
  task automatic pin(input logic [31:0] got, input logic [31:0] exp);
    cmp(got, exp);
  endtask : pin

  task automatic settle;
    repeat (6) @(posedge core_clk_i);
  endtask : settle

  task automatic wrap_up;
    $display("checks=%0d mismatches=%0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : wrap_up

  // ****************************************************
  // tests
  // ****************************************************
  initial begin
    repeat (8) @(posedge core_clk_i);
    srst_i <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      rd(8'(4 * i), 32'h0, 1'b0);
    end
    rd(8'h1C, 32'h0, 1'b1);
    $display("test reset values done");
    wr(F, 16'hFFFF);
    rd(F, 32'h0000F000, 1'b0);
    wr(HD, 16'hFFFF);
    rd(HD, 32'h0000003F, 1'b0);
    wr(GU, 16'h1234);
    rd(GU, 32'h00001234, 1'b0);
    $display("test reserved bits done");
    settle();
    pin(32'(own), 32'h3);
    pin(32'(f14_oe), 32'h1);
    pin(32'(f14_out), 32'h1);
    pin(32'(rx), 32'h0);
    tx <= 1'b0;
    f15_in <= 1'b1;
    settle();
    pin(32'({f14_out, rx}), 32'h1);
    f14p <= 2'h1;
    f15p <= 2'h3;
    settle();
    pin(32'({own, f14_oe, rx}), 32'h1);
    f14p <= 2'h0;
    f15p <= 2'h0;
    wr(F, 16'h5000);
    settle();
    pin(32'({own, f14_oe}), 32'h0);
    wr(F, 16'hA000);
    settle();
    pin(32'({own, f14_oe}), 32'h0);
    $display("test port f extra done");
    wr(HD, 16'h002A);
    settle();
    pin(32'(h_oe), 32'h2A);
    pin(32'(h_out), 32'(hdat));
    hmode <= 6'h0F;
    settle();
    pin(32'(h_oe), 32'h0A);
    $display("test port h done");
    wr(GU, 16'h0000);
    wr(GD, 16'hA5C3);
    settle();
    pin(32'(g_oe), 32'hA5C3);
    pin(32'(g_out), 32'(gdat));
    wr(GU, 16'h5555);
    wr(GL, 16'h5555);
    settle();
    pin(32'(g_oe), 32'hFFFF);
    pin(32'(g_out), 32'(tmr));
    wr(GU, 16'hAAAA);
    wr(GL, 16'hAAAA);
    settle();
    pin(32'(g_oe), 32'hFFBF);
    sel_map = {spa[7:4], spc[2:0], spb[2:1], 1'b0, spa[5:0]};
    pin(32'(g_out & 16'hFFBF), 32'(sel_map));
    pin(32'(a_in), 32'(spa[0]));
    pin(32'(b_in), 32'(g_board[6]));
    pin(32'(c_in), 32'(spc[0]));
    // turn the bidirectional selects around
    s0oe <= 3'h2;
    settle();
    pin(32'(g_oe), 32'hFDFE);
    pin(32'(a_in), 32'(g_board[0]));
    pin(32'(b_in), 32'(spb[0]));
    pin(32'(c_in), 32'(g_board[9]));
    wr(GD, 16'hFFFF);
    wr(GU, 16'hFFFF);
    wr(GL, 16'hFFFF);
    settle();
    pin(32'(g_oe), 32'h00FF);
    sel_map = {8'h00, gdat[7:6], spc[3], spb[3], gdat[3:0]};
    pin(32'(g_out[7:0]), 32'(sel_map));
    pin(32'(tin), 32'(g_board[15:8]));
    rd(8'h14, 32'({g_board[15:8], sel_map[7:0]}), 1'b0);
    sel_map = {9'h000, f15_in, (hdat & 6'h0A) | (h_board & 6'h35)};
    rd(8'h18, 32'(sel_map), 1'b0);
    $display("test port g done");
    srst_i <= 1'b1;
    repeat (3) @(posedge core_clk_i);
    srst_i <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      rd(8'(4 * i), 32'h0, 1'b0);
    end
    pin(32'({g_oe, h_oe}), 32'h0);
    pin(32'({own, rx}), 32'h1);
    $display("test second reset done");
    wrap_up();
  end

  // watchdog
  initial begin
    #(40 * 5000);
    err_total++;
    wrap_up();
  end
endmodule : port_fgh_pin_function_select_tb
